// *** rtl/sdqc_defs.svh ***
`ifndef SDQC_DEFS_SVH
`define SDQC_DEFS_SVH
// Sampling clock rate in kHz (20 MHz)
`define SDQC_CLK_KHZ        20000
// Least pulse phase width, ns
`define SDQC_MIN_PULSE_NS   1000
// Least pulse width in cycles, rounded up
`define SDQC_MIN_PULSE_CYC  ((`SDQC_MIN_PULSE_NS * `SDQC_CLK_KHZ + 999999) / 1000000)
// Least spacing between adjacent quadrature edges, ns
`define SDQC_QUAD_GAP_NS    25
// Delay from enable low to disabled, ms
`define SDQC_DISABLE_MS     10
// Disable delay in cycles
`define SDQC_DISABLE_CYC    (`SDQC_DISABLE_MS * `SDQC_CLK_KHZ)
// Encoder counts per revolution
`define SDQC_ENC_CPR        6400
// Commutation start-up time in cycles
`define SDQC_COMMUT_CYC     2000
// LED flicker half period and blink timing, cycles
`define SDQC_FLICK_CYC      200000
`define SDQC_BLINK_CYC      4000000
// Blink counts per shutdown cause
`define SDQC_BLINKS_USER    2
`define SDQC_BLINKS_OVOLT   3
`endif

// *** rtl/sdqc_pkg.sv ***
package sdqc_pkg;
    // Command pin format
    typedef enum logic {
        SDQC_FMT_STEP_DIR = 1'b0,
        SDQC_FMT_QUAD     = 1'b1
    } sdqc_fmt_t;
    // Drive state, Gray coded along the enable path
    typedef enum logic [1:0] {
        SDQC_ST_DISABLED = 2'b00,
        SDQC_ST_COMMUT   = 2'b01,
        SDQC_ST_ENABLED  = 2'b11,
        SDQC_ST_SHUTDOWN = 2'b10
    } sdqc_state_t;
    // Shutdown exception type, readable by a host
    typedef enum logic [1:0] {
        SDQC_EXC_NONE     = 2'b00,
        SDQC_EXC_USER     = 2'b01,
        SDQC_EXC_CONFLICT = 2'b10,
        SDQC_EXC_OVOLT    = 2'b11
    } sdqc_exc_t;
    // LED colour
    typedef enum logic [1:0] {
        SDQC_LED_OFF    = 2'b00,
        SDQC_LED_YELLOW = 2'b01,
        SDQC_LED_GREEN  = 2'b10
    } sdqc_led_t;
endpackage

// *** rtl/sdqc_link_if.sv ***
`timescale 1ns/10ps
// Command pins between controller and drive
interface sdqc_link_if;
    logic pin_a;
    logic pin_b;
    logic pin_en;
    modport controller (output pin_a, output pin_b, output pin_en);
    modport drive      (input pin_a, input pin_b, input pin_en);
endinterface

// *** rtl/sdqc_controller.sv ***
`timescale 1ns/10ps
`include "sdqc_defs.svh"
// Controller end: issues step/dir or quadrature commands with legal timing
module sdqc_controller
    import sdqc_pkg::*;
#(
    parameter int PHASE_CYC = `SDQC_MIN_PULSE_CYC
) (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // User side
    input  wire logic       i_fmt,
    input  wire logic       i_enable,
    input  wire logic       i_move,
    input  wire logic       i_clockwise,
    output logic            o_ready,
    // Link
    sdqc_link_if.controller link
);
    logic [15:0] tmr;
    logic        busy;
    logic        phase;
    logic        dir;
    logic        pin_a;
    logic        pin_b;
    logic        pin_en;
    logic        ready;

    wire tmr_done = (tmr == 16'h0000);
    // Quadrature state read back from the pins, so a format change never moves both channels
    wire [1:0] quad = {pin_a, pin_b};
    // Gray step forward or backward; A leads B for clockwise
    wire [1:0] quad_fwd = {~quad[0], quad[1]};
    wire [1:0] quad_bwd = {quad[0], ~quad[1]};

    // Each phase is held a full minimum width, so edge gaps exceed 25 ns too
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tmr    <= 16'h0000;
            busy   <= 1'b0;
            phase  <= 1'b0;
            dir    <= 1'b0;
            pin_a  <= 1'b0;
            pin_b  <= 1'b0;
            pin_en <= 1'b0;
            ready  <= 1'b0;
        end else begin
            pin_en <= i_enable;
            ready  <= !busy && tmr_done && !i_move;
            if (!tmr_done) begin
                tmr <= tmr - 16'h0001;
            end else if (busy) begin
                if (i_fmt == SDQC_FMT_STEP_DIR) begin
                    pin_b <= ~phase;
                    busy  <= ~phase;
                end else begin
                    pin_a <= dir ? quad_fwd[1] : quad_bwd[1];
                    pin_b <= dir ? quad_fwd[0] : quad_bwd[0];
                    busy  <= 1'b0;
                end
                phase <= ~phase;
                tmr   <= 16'(PHASE_CYC);
            end else if (i_move) begin
                dir   <= i_clockwise;
                busy  <= 1'b1;
                phase <= 1'b0;
                if (i_fmt == SDQC_FMT_STEP_DIR) begin
                    pin_a <= i_clockwise;
                    tmr   <= 16'(PHASE_CYC);
                end
            end
        end
    end

    assign link.pin_a  = pin_a;
    assign link.pin_b  = pin_b;
    assign link.pin_en = pin_en;
    assign o_ready     = ready;
endmodule

// *** rtl/sdqc_drive.sv ***
`timescale 1ns/10ps
`include "sdqc_defs.svh"
module sdqc_drive
    import sdqc_pkg::*;
#(
    parameter int DISABLE_CYC = `SDQC_DISABLE_CYC,
    parameter int COMMUT_CYC  = `SDQC_COMMUT_CYC,
    parameter int FLICK_CYC   = `SDQC_FLICK_CYC,
    parameter int BLINK_CYC   = `SDQC_BLINK_CYC,
    parameter int ENC_CPR     = `SDQC_ENC_CPR
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Link
    sdqc_link_if.drive       link,
    // Configuration
    input  wire logic        i_fmt,
    input  wire logic [15:0] i_resolution,
    // Host events
    input  wire logic        i_user_stop,
    input  wire logic        i_override_mismatch,
    input  wire logic        i_over_voltage,
    // Motion and status
    output logic             o_move_valid,
    output logic signed [9:0] o_move_counts,
    output logic             o_servo_on,
    output logic             o_res_error,
    output logic [1:0]       o_led,
    output logic [1:0]       o_exception
);
    localparam int FLT_CYC = `SDQC_MIN_PULSE_CYC;

    // Resolution legality check, used for scaling and error flag
    function automatic logic res_legal(input logic [15:0] r);
        case (r)
            16'h00C8, 16'h0190, 16'h0320, 16'h0640, 16'h0C80,
            16'h1900, 16'h3200, 16'h6400, 16'hC800: res_legal = 1'b1;
            default: res_legal = 1'b0;
        endcase
    endfunction

    // Three-flop sampling per pin; second and third must agree
    logic [2:0] sync [3];
    logic [2:0] filt;
    logic [5:0] fcnt [3];
    wire  [2:0] pins = {link.pin_en, link.pin_b, link.pin_a};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            wire agree   = (sync[g][1] == sync[g][2]);
            wire differs = agree && (sync[g][2] != filt[g]);
            // Level must hold 1us before it is accepted as a new level
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync[g] <= 3'b000;
                    fcnt[g] <= 6'h00;
                    filt[g] <= 1'b0;
                end else begin
                    sync[g] <= {sync[g][1:0], pins[g]};
                    if (!differs) begin
                        fcnt[g] <= 6'h00;
                    end else if (fcnt[g] == 6'(FLT_CYC - 1)) begin
                        filt[g] <= sync[g][2];
                        fcnt[g] <= 6'h00;
                    end else begin
                        fcnt[g] <= fcnt[g] + 6'h01;
                    end
                end
            end
        end
    endgenerate

    logic [2:0] filt_q;
    wire a_now = filt[0];
    wire b_now = filt[1];
    wire en_now = filt[2];
    wire step_rise = b_now && !filt_q[1];
    wire a_chg = a_now ^ filt_q[0];
    wire b_chg = b_now ^ filt_q[1];
    // Clockwise when A changes to differ from B, or B changes to match A
    wire quad_cw = a_chg ? (a_now != b_now) : (a_now == b_now);
    wire quad_ev = a_chg ^ b_chg;
    wire is_quad = (i_fmt == SDQC_FMT_QUAD);
    wire in_ev = is_quad ? quad_ev : step_rise;
    wire in_cw = is_quad ? quad_cw : a_now;
    wire en_rise = en_now && !filt_q[2];
    wire en_fall = !en_now && filt_q[2];

    // Encoder counts per input count
    wire [15:0] mult = res_legal(i_resolution) ?
                       16'(ENC_CPR / ((i_resolution == 16'h0000) ? 1 : i_resolution)) :
                       16'h0000;
    // Resolutions above the encoder CPR need several inputs per count
    wire [15:0] group = (mult == 16'h0000 && res_legal(i_resolution)) ?
                        16'(i_resolution / ENC_CPR) : 16'h0001;

    sdqc_state_t state;
    sdqc_state_t next_state;
    sdqc_exc_t   exc;
    logic [31:0] tmr;
    logic [15:0] grp_cnt;
    logic        disabling;
    logic        move_valid;
    logic signed [9:0] move_counts;
    wire shut_ev = i_user_stop || i_over_voltage;
    // A shutdown cause in the same cycle already refuses the step
    wire accepting = (state == SDQC_ST_ENABLED) && !disabling && !shut_ev;
    wire scaled_out = (mult != 16'h0000) ? 1'b1 : (grp_cnt == group - 16'h0001);

    // Next drive state
    always_comb begin
        next_state = state;
        case (state)
            SDQC_ST_DISABLED: if (en_rise) next_state =
                i_override_mismatch ? SDQC_ST_SHUTDOWN : SDQC_ST_COMMUT;
            SDQC_ST_COMMUT: if (tmr == 32'h0) next_state = SDQC_ST_ENABLED;
            SDQC_ST_ENABLED: ;
            SDQC_ST_SHUTDOWN: if (en_fall) next_state = SDQC_ST_DISABLED;
            default: next_state = SDQC_ST_DISABLED;
        endcase
        if ((state == SDQC_ST_COMMUT || state == SDQC_ST_ENABLED) && shut_ev)
            next_state = SDQC_ST_SHUTDOWN;
        else if (disabling && tmr == 32'h0)
            next_state = SDQC_ST_DISABLED;
    end

    // State, timers, exception record and scaled motion output
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= SDQC_ST_DISABLED;
            exc <= SDQC_EXC_NONE;
            tmr <= 32'h0;
            disabling <= 1'b0;
            grp_cnt <= 16'h0000;
            filt_q <= 3'b000;
            move_valid <= 1'b0;
            move_counts <= 10'sh000;
        end else begin
            filt_q <= filt;
            state <= next_state;
            if (tmr != 32'h0) tmr <= tmr - 32'h1;
            if (state == SDQC_ST_DISABLED && next_state == SDQC_ST_COMMUT) begin
                tmr <= 32'(COMMUT_CYC);
                exc <= SDQC_EXC_NONE;
            end
            if (next_state == SDQC_ST_SHUTDOWN && state != SDQC_ST_SHUTDOWN) begin
                exc <= (state == SDQC_ST_DISABLED) ? SDQC_EXC_CONFLICT :
                       (i_over_voltage ? SDQC_EXC_OVOLT : SDQC_EXC_USER);
                disabling <= 1'b0;
            end else if (en_fall && (state == SDQC_ST_COMMUT || state == SDQC_ST_ENABLED)) begin
                disabling <= 1'b1;
                tmr <= 32'(DISABLE_CYC);
            end else if (next_state == SDQC_ST_DISABLED) begin
                disabling <= 1'b0;
            end
            move_valid <= 1'b0;
            if (accepting && in_ev) begin
                grp_cnt <= scaled_out ? 16'h0000 : grp_cnt + 16'h0001;
                if (scaled_out && res_legal(i_resolution)) begin
                    move_valid <= 1'b1;
                    move_counts <= in_cw ? $signed({1'b0, mult[8:0] | {8'h00, mult == 16'h0000}})
                                         : -$signed({1'b0, mult[8:0] | {8'h00, mult == 16'h0000}});
                end
            end
        end
    end

    // LED pattern: blinks then a gap, repeating while in shutdown
    logic [31:0] led_tmr;
    logic [3:0]  blink_idx;
    logic        flick;
    logic [1:0]  led;
    logic        servo_on;
    logic        res_error;
    wire [3:0] blinks = (exc == SDQC_EXC_OVOLT) ? 4'(`SDQC_BLINKS_OVOLT) :
                        4'(`SDQC_BLINKS_USER);
    wire blink_on = !flick && (blink_idx < blinks);
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            led_tmr <= 32'h0;
            blink_idx <= 4'h0;
            flick <= 1'b0;
            led <= SDQC_LED_OFF;
            servo_on <= 1'b0;
            res_error <= 1'b0;
        end else begin
            if (state == SDQC_ST_SHUTDOWN && led_tmr == 32'h0) begin
                led_tmr <= 32'(BLINK_CYC);
                flick <= ~flick;
                if (flick) blink_idx <= (blink_idx == blinks + 4'h1) ? 4'h0 : blink_idx + 4'h1;
            end else if (state != SDQC_ST_SHUTDOWN && led_tmr == 32'h0) begin
                led_tmr <= 32'(FLICK_CYC);
                flick <= ~flick;
                blink_idx <= 4'h0;
            end else begin
                led_tmr <= led_tmr - 32'h1;
            end
            // Colour follows the state being entered, so it lines up with the servo flag
            case (next_state)
                SDQC_ST_DISABLED: led <= SDQC_LED_YELLOW;
                SDQC_ST_COMMUT:   led <= flick ? SDQC_LED_YELLOW : SDQC_LED_OFF;
                SDQC_ST_ENABLED:  led <= flick ? SDQC_LED_GREEN : SDQC_LED_OFF;
                default:          led <= blink_on ? SDQC_LED_YELLOW : SDQC_LED_OFF;
            endcase
            servo_on <= (next_state == SDQC_ST_COMMUT) || (next_state == SDQC_ST_ENABLED);
            res_error <= !res_legal(i_resolution);
        end
    end

    assign o_move_valid = move_valid;
    assign o_move_counts = move_counts;
    assign o_servo_on = servo_on;
    assign o_res_error = res_error;
    assign o_led = led;
    assign o_exception = exc;
endmodule

// *** tb/sdqc_link_chk.sv ***
`timescale 1ns/10ps
// Watches the command pins and the drive's status outputs
module sdqc_link_chk
    import sdqc_pkg::*;
#(
    parameter int PHASE_CYC   = 20,
    parameter int DISABLE_CYC = 100
) (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_n,
    input wire logic       pin_a,
    input wire logic       pin_b,
    input wire logic       pin_en,
    input wire logic       o_move_valid,
    input wire logic       o_servo_on,
    input wire logic [1:0] o_led,
    input wire logic [1:0] o_exception
);
    localparam int DIS_HI = DISABLE_CYC + 40;
    logic [15:0] run_a;
    logic [15:0] run_b;
    logic [15:0] low_cnt;
    logic        a_q;
    logic        b_q;
    logic        live;
    // Counters saturate so a long idle never wraps into a false short phase
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {a_q, b_q, live} <= 3'h0;
            run_a            <= 16'hFFFF;
            run_b            <= 16'hFFFF;
            low_cnt          <= 16'h0000;
        end else begin
            {a_q, b_q, live} <= {pin_a, pin_b, 1'b1};
            run_a   <= (pin_a != a_q) ? 16'h0000 : run_a + 16'(run_a != 16'hFFFF);
            run_b   <= (pin_b != b_q) ? 16'h0000 : run_b + 16'(run_b != 16'hFFFF);
            low_cnt <= pin_en ? 16'h0000 : low_cnt + 16'(low_cnt != 16'hFFFF);
        end
    end
    // Start-up keeps the green colour away for a while
    sequence s_commut_led;
        (o_led != SDQC_LED_GREEN) [*8];
    endsequence
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_phase_a: assert property (pin_a != a_q |-> run_a >= PHASE_CYC - 1)
        else $error("channel A phase too short");
    b_phase_a: assert property (pin_b != b_q |-> run_b >= PHASE_CYC - 1)
        else $error("channel B phase too short");
    edge_gap_a: assert property (!(pin_a != a_q && pin_b != b_q))
        else $error("both channels changed together");
    commut_led_a: assert property ($rose(o_servo_on) |-> s_commut_led)
        else $error("green shown during start-up");
    motion_gate_a: assert property (o_move_valid |-> o_servo_on && o_exception == 2'h0)
        else $error("motion while not enabled");
    servo_enable_a: assert property ($rose(o_servo_on) |-> pin_en && $past(pin_en, 8))
        else $error("servo on without enable");
    disable_late_a: assert property ($fell(o_servo_on) && !pin_en |-> low_cnt >= DISABLE_CYC)
        else $error("disabled too early");
    disable_done_a: assert property (low_cnt > DIS_HI |-> !o_servo_on)
        else $error("disable took too long");
    idle_led_a: assert property (live && !o_servo_on && o_exception == 2'h0
        |-> o_led == SDQC_LED_YELLOW) else $error("idle LED not yellow");
    shutdown_off_a: assert property ($changed(o_exception) && o_exception != 2'h0
        |-> ##[0:2] !o_servo_on) else $error("servo left on at shutdown");
endmodule

// *** tb/sdqc_test.sv ***
`timescale 1ns/10ps
`include "sdqc_defs.svh"
// Controller and drive face each other; a second drive faces the bench directly
module sdqc_test import sdqc_pkg::*;;
    logic               clk, rst_n, fmt, en, move, cw, ready, stop, mism, ovolt;
    logic               mv, mv2, servo, res_err;
    logic [15:0]        res;
    logic signed [9:0]  cnt, cnt2;
    logic [1:0]         led, exc;
    logic signed [31:0] sum, sum2;
    int                 failures, n_tests;
    int                 rtab[9] = '{200, 400, 800, 1600, 3200, 6400, 12800, 25600, 51200};
    sdqc_exc_t          xtab[3] = '{SDQC_EXC_USER, SDQC_EXC_CONFLICT, SDQC_EXC_OVOLT};
    sdqc_link_if link ();
    sdqc_link_if link2 ();
    // Link timing runs at its default width; only delays too long to simulate are shortened
    sdqc_controller sdqc_controller_inst (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_fmt(fmt), .i_enable(en), .i_move(move), .i_clockwise(cw), .o_ready(ready),
        .link(link));
    sdqc_drive #(.DISABLE_CYC(100), .COMMUT_CYC(20), .FLICK_CYC(4), .BLINK_CYC(8))
        sdqc_drive_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .link(link), .i_fmt(fmt),
        .i_resolution(res), .i_user_stop(stop), .i_override_mismatch(mism),
        .i_over_voltage(ovolt), .o_move_valid(mv), .o_move_counts(cnt), .o_servo_on(servo),
        .o_res_error(res_err), .o_led(led), .o_exception(exc));
    sdqc_drive #(.COMMUT_CYC(20))
        sdqc_drive_inst_b (.i_ref_clk(clk), .i_rst_n(rst_n), .link(link2), .i_fmt(fmt),
        .i_resolution(res), .i_user_stop(stop), .i_override_mismatch(mism),
        .i_over_voltage(ovolt), .o_move_valid(mv2), .o_move_counts(cnt2), .o_servo_on(),
        .o_res_error(), .o_led(), .o_exception());
    sdqc_link_chk sdqc_link_chk_inst (.i_ref_clk(clk),
        .i_rst_n(rst_n), .pin_a(link.pin_a), .pin_b(link.pin_b), .pin_en(link.pin_en),
        .o_move_valid(mv), .o_servo_on(servo), .o_led(led), .o_exception(exc));
    // Free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Running totals of motion reported by each drive
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum  <= '0;
            sum2 <= '0;
        end else begin
            if (mv) sum <= sum + cnt;
            if (mv2) sum2 <= sum2 + cnt2;
        end
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // Bounded wait so a stuck handshake cannot hang the run
    task wait_ready(input logic lvl);
        for (int t = 0; t < 200 && ready !== lvl; t++) cyc(1);
        if (ready !== lvl) chk(ready, lvl, "ready");
    endtask
    task step(input logic dir, input int n);
        for (int k = 0; k < n; k++) begin
            cw   = dir;
            move = 1'b1;
            wait_ready(1'b0);
            move = 1'b0;
            wait_ready(1'b1);
        end
        cyc(30);
    endtask
    // Covers the input filter plus start-up, or filter plus disable delay
    task enable(input logic lvl);
        en = lvl;
        cyc(lvl ? 60 : 160);
    endtask
    task pulse2(input int n);
        link2.pin_b = 1'b1;
        cyc(n);
        link2.pin_b = 1'b0;
        cyc(40);
    endtask
    // Yellow flashes over one code period; 18 cycles is one on/off pair at BLINK_CYC 8
    task blink_chk(input int nb);
        int   seen;
        logic was;
        seen = 0;
        was  = (led == SDQC_LED_YELLOW);
        repeat ((nb + 2) * 18) begin
            cyc(1);
            if (led == SDQC_LED_YELLOW && !was) seen++;
            was = (led == SDQC_LED_YELLOW);
        end
        chk(seen, nb, "blinks");
    endtask
    task end_sim();
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #1_000_000;
        failures++;
        end_sim();
    end
    initial begin
        logic signed [31:0] base;
        int                 exp_sum;
        {rst_n, fmt, en, move, cw, stop, mism, ovolt} = '0;
        {link2.pin_a, link2.pin_b, link2.pin_en} = 3'h0;
        res = 16'h1900;
        cyc(20);
        rst_n = 1'b1;
        cyc(2);
        // Bench-driven link: glitch, whole pulse, then opposite direction
        link2.pin_en = 1'b1;
        link2.pin_a  = 1'b1;
        cyc(60);
        pulse2(10);
        chk(sum2, 0, "glitch");
        pulse2(25);
        chk(sum2, 1, "one step");
        link2.pin_a = 1'b0;
        cyc(30);
        pulse2(25);
        chk(sum2, 0, "reverse");
        enable(1'b1);
        chk(servo, 1, "enabled");
        // Every legal resolution, with the scale each one implies
        exp_sum = 0;
        foreach (rtab[i]) begin
            res = rtab[i][15:0];
            cyc(2);
            chk(res_err, 0, "legal res");
            base = sum;
            step(1'b1, rtab[i] <= `SDQC_ENC_CPR ? 1 : rtab[i] / `SDQC_ENC_CPR);
            chk(sum - base, rtab[i] <= `SDQC_ENC_CPR ? `SDQC_ENC_CPR / rtab[i] : 1, "scale");
            exp_sum += rtab[i] <= `SDQC_ENC_CPR ? `SDQC_ENC_CPR / rtab[i] : 1;
        end
        res = 16'h0320;
        step(1'b0, 1);
        exp_sum -= `SDQC_ENC_CPR / 800;
        chk(sum, exp_sum, "ccw");
        res = 16'h03E8;
        step(1'b1, 1);
        chk(res_err, 1, "bad res");
        chk(sum, exp_sum, "refused");
        // Quadrature: one count per edge, sign from channel order
        {fmt, res} = {1'b1, 16'h1900};
        cyc(30);
        base = sum;
        // Five forward, two back; ends with both channels low for the step tests after
        step(1'b1, 5);
        step(1'b0, 2);
        chk(sum - base, 3, "quad");
        fmt = 1'b0;
        en  = 1'b0;
        cyc(60);
        chk(servo, 1, "still on");
        cyc(100);
        chk(servo, 0, "disabled");
        chk(led, SDQC_LED_YELLOW, "idle led");
        // Each shutdown cause, refused motion, then cleared by toggling enable
        for (int k = 0; k < 3; k++) begin
            mism = (k == 1);
            enable(1'b1);
            stop  = (k == 0);
            ovolt = (k == 2);
            cyc(5);
            {stop, mism, ovolt} = '0;
            chk(servo, 0, "shutdown");
            chk(exc, xtab[k], "cause");
            blink_chk(k == 2 ? `SDQC_BLINKS_OVOLT : `SDQC_BLINKS_USER);
            base = sum;
            step(1'b1, 1);
            chk(sum - base, 0, "no motion");
            enable(1'b0);
            enable(1'b1);
            chk({servo, exc}, 3'h4, "cleared");
            enable(1'b0);
        end
        end_sim();
    end
endmodule
